// ---- ufm_cfg.svh ----
// register map, field positions, reset values and timing counts
`ifndef UFM_CFG_SVH
`define UFM_CFG_SVH
`define UFM_ADDR_CTRL  8'hd2
`define UFM_ADDR_DBUF  8'hd3
`define UFM_ADDR_FMT   8'he5
`define UFM_CTRL_RST   8'h20
`define UFM_FMT_RST    8'h0c
`define UFM_DBUF_RST   8'h00
// control/status bit positions
`define UFM_B_OVR      7
`define UFM_B_PERR     6
`define UFM_B_REN      4
`define UFM_B_TBX      3
`define UFM_B_TI       1
`define UFM_B_RI       0
// frame format bit positions
`define UFM_B_MCE      7
`define UFM_B_PT       6:5
`define UFM_B_PE       4
`define UFM_B_DL       3:2
`define UFM_B_XBE      1
`define UFM_B_SBL      0
// oversample ticks per bit and receive queue depth
`define UFM_OVS_DEF    16
`define UFM_RXQ_DEPTH  3
`endif

// ---- ufm_pkg.sv ----
// types shared by the serial port core
package ufm_pkg;
  typedef enum logic [2:0] {
    UFM_IDLE  = 3'b000,
    UFM_START = 3'b001,
    UFM_DATA  = 3'b011,
    UFM_EXTRA = 3'b010,
    UFM_STOP  = 3'b110
  } ufm_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic       xbit;
    logic       perr;
  } ufm_entry_t;
endpackage

// ---- ufm_core.sv ----
// full-duplex serial port core with receive queue and address mode
`timescale 1ns/1ps
`include "ufm_cfg.svh"
// Notes on behaviour
// - data write loads holding register, clears empty
// - idle shifter takes held byte, empty set
// - busy shifter leaves byte waiting in holder
// - done flag at stop-bit start, interrupt
// - extra bit sent when enabled, no parity
// - parity bit computed and sent when enabled
// - receive only while enabled; queue stays readable
// - store byte if room and stops high
// - full queue drops byte, sticky overrun flag
// - low stop bit means byte not stored
// - receive flag on store; address gating
// - read returns oldest, frees slot
// - receive flag clear ignored while two or more bytes wait
// - extra bit view shows extra or stop
// - parity mismatch sets sticky parity error
// - transmit done flag cleared only by software
// - start low, lsb first, extra, stop high
// - parity type odd even mark space
// - length code selects five to eight bits
// - long stop two bits, or 1.5
module ufm_core #(
  parameter int OVS   = `UFM_OVS_DEF,
  parameter int DEPTH = `UFM_RXQ_DEPTH
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic       os_tick_i,
  input  wire logic       serial_in_pin_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            serial_out_pin_o,
  output logic            irq_o
);
  localparam int CW = $clog2(2 * OVS);
  localparam int IW = $clog2(DEPTH);
  localparam int NW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] BIT_M1  = CW'(OVS - 1);
  localparam logic [CW-1:0] HALF_M1 = CW'(OVS / 2 - 1);
  localparam logic [CW-1:0] TWO_M1  = CW'(2 * OVS - 1);
  localparam logic [CW-1:0] ONEH_M1 = CW'(OVS + OVS / 2 - 1);
  localparam logic [NW-1:0] FULL_N  = NW'(DEPTH);

  // oversampling must allow a true mid-bit point; queue needs two slots
  if (OVS < 4 || (OVS % 2) != 0 || DEPTH < 2) begin : g_bad
    $error("ufm_core: OVS must be even and >= 4, DEPTH >= 2");
  end

  // parity of the active data bits for the chosen type
  function automatic logic par_f(input logic [7:0] d,
                                 input logic [1:0] dl,
                                 input logic [1:0] pt);
    logic [7:0] m;
    m = d & (8'hff >> (2'd3 - dl));
    case (pt)
      2'b00:   par_f = ~^m; // odd
      2'b01:   par_f = ^m;  // even
      2'b10:   par_f = 1'b1;
      default: par_f = 1'b0;
    endcase
  endfunction

  logic [7:0] fmt_q;
  logic       ren_q, tbx_q, ti_q, ri_q, ovr_q, perr_q;
  logic [7:0] hold_q;
  logic       hold_full_q;
  logic [7:0] rdata_q;
  logic       irq_q;

  // register decode
  wire wr_ctrl = sfr_wr_i && (sfr_addr_i == `UFM_ADDR_CTRL);
  wire wr_dbuf = sfr_wr_i && (sfr_addr_i == `UFM_ADDR_DBUF);
  wire wr_fmt  = sfr_wr_i && (sfr_addr_i == `UFM_ADDR_FMT);
  wire rd_dbuf = sfr_rd_i && (sfr_addr_i == `UFM_ADDR_DBUF);

  // frame format fields
  wire       mce   = fmt_q[`UFM_B_MCE];
  wire [1:0] pt    = fmt_q[`UFM_B_PT];
  wire       pe    = fmt_q[`UFM_B_PE];
  wire [1:0] dl    = fmt_q[`UFM_B_DL];
  wire       xbe   = fmt_q[`UFM_B_XBE];
  wire       has_x = pe | xbe;
  wire       long2 = fmt_q[`UFM_B_SBL] && (dl != 2'b00);
  wire       longh = fmt_q[`UFM_B_SBL] && (dl == 2'b00);
  wire [2:0] last_bit = {1'b0, dl} + 3'd4;
  wire [CW-1:0] stop_m1 = long2 ? TWO_M1 : (longh ? ONEH_M1 : BIT_M1);

  // ---------------- transmitter ----------------
  ufm_pkg::ufm_state_t tx_q;
  logic [CW-1:0] tx_tc_q;
  logic [2:0]    tx_bc_q;
  logic [7:0]    tx_sh_q;
  logic          tx_x_q;
  logic          out_q;

  wire [CW-1:0] tx_lim  = (tx_q == ufm_pkg::UFM_STOP) ? stop_m1 : BIT_M1;
  wire          tx_end  = os_tick_i && (tx_tc_q == tx_lim);
  wire          tx_load = (tx_q == ufm_pkg::UFM_IDLE) && hold_full_q;
  wire          tx_last = tx_bc_q == last_bit;
  wire          tx_to_stop = tx_end &&
                  ((tx_q == ufm_pkg::UFM_DATA && tx_last && !has_x) ||
                   tx_q == ufm_pkg::UFM_EXTRA);
  // a loaded byte picks its extra bit at load time; length, extra enable and stop length stay live
  wire tx_x_d = pe ? par_f(hold_q, dl, pt) : tbx_q;

  // transmit state machine; idle reload gives back-to-back frames
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_q    <= ufm_pkg::UFM_IDLE;
      tx_tc_q <= '0;
      tx_bc_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_x_q  <= 1'b0;
    end else begin
      if (tx_q == ufm_pkg::UFM_IDLE || tx_end) tx_tc_q <= '0;
      else if (os_tick_i) tx_tc_q <= tx_tc_q + 1'b1;
      case (tx_q)
        ufm_pkg::UFM_IDLE: if (tx_load) begin
          tx_sh_q <= hold_q;
          tx_x_q  <= tx_x_d;
          tx_q    <= ufm_pkg::UFM_START;
        end
        ufm_pkg::UFM_START: if (tx_end) begin
          tx_bc_q <= 3'h0;
          tx_q    <= ufm_pkg::UFM_DATA;
        end
        ufm_pkg::UFM_DATA: if (tx_end) begin // lsb first
          tx_sh_q <= tx_sh_q >> 1;
          tx_bc_q <= tx_bc_q + 3'h1;
          if (tx_last)
            tx_q <= has_x ? ufm_pkg::UFM_EXTRA : ufm_pkg::UFM_STOP;
        end
        ufm_pkg::UFM_EXTRA: if (tx_end) tx_q <= ufm_pkg::UFM_STOP;
        default: if (tx_end) tx_q <= ufm_pkg::UFM_IDLE;
      endcase
    end
  end

  // line level follows the state one clock later
  wire out_d = (tx_q == ufm_pkg::UFM_START) ? 1'b0 :
               (tx_q == ufm_pkg::UFM_DATA)  ? tx_sh_q[0] :
               (tx_q == ufm_pkg::UFM_EXTRA) ? tx_x_q : 1'b1;

  // holding register: a write during load keeps the new byte waiting
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_q      <= `UFM_DBUF_RST;
      hold_full_q <= 1'b0;
    end else if (wr_dbuf) begin
      hold_q      <= sfr_wdata_i;
      hold_full_q <= 1'b1;
    end else if (tx_load) begin
      hold_full_q <= 1'b0;
    end
  end

  // ---------------- receiver ----------------
  ufm_pkg::ufm_state_t rx_q;
  logic          s1_q, s2_q, s3_q;
  logic [CW-1:0] rx_tc_q;
  logic [2:0]    rx_bc_q;
  logic [7:0]    rx_sh_q;
  logic          rx_x_q, rx_ok_q, rx_2nd_q;

  wire fall = s3_q && !s2_q;
  wire [CW-1:0] rx_lim = (rx_q == ufm_pkg::UFM_START) ? HALF_M1 : BIT_M1;
  wire rx_smp  = os_tick_i && (rx_tc_q == rx_lim); // mid-bit
  wire rx_last = rx_bc_q == last_bit;
  wire rx_fin  = (rx_q == ufm_pkg::UFM_STOP) && rx_smp &&
                 !(long2 && !rx_2nd_q);
  wire stop_ok = s2_q && (rx_2nd_q ? rx_ok_q : 1'b1);
  wire [7:0] rx_data = rx_sh_q >> (2'd3 - dl);
  wire rx_xb   = (has_x || rx_2nd_q) ? rx_x_q : s2_q;

  // input synchroniser; second stage feeds sampling, second and third stages feed the edge detect
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= serial_in_pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // receive state machine; disabling aborts any frame in flight
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_q     <= ufm_pkg::UFM_IDLE;
      rx_tc_q  <= '0;
      rx_bc_q  <= 3'h0;
      rx_sh_q  <= 8'h00;
      rx_x_q   <= 1'b0;
      rx_ok_q  <= 1'b0;
      rx_2nd_q <= 1'b0;
    end else if (!ren_q) begin
      rx_q <= ufm_pkg::UFM_IDLE;
    end else begin
      if (rx_q == ufm_pkg::UFM_IDLE || rx_smp) rx_tc_q <= '0;
      else if (os_tick_i) rx_tc_q <= rx_tc_q + 1'b1;
      case (rx_q)
        ufm_pkg::UFM_IDLE: if (fall) rx_q <= ufm_pkg::UFM_START;
        ufm_pkg::UFM_START: if (rx_smp) begin // glitch check
          rx_bc_q <= 3'h0;
          rx_q    <= s2_q ? ufm_pkg::UFM_IDLE : ufm_pkg::UFM_DATA;
        end
        ufm_pkg::UFM_DATA: if (rx_smp) begin
          rx_sh_q  <= {s2_q, rx_sh_q[7:1]};
          rx_bc_q  <= rx_bc_q + 3'h1;
          rx_2nd_q <= 1'b0;
          if (rx_last)
            rx_q <= has_x ? ufm_pkg::UFM_EXTRA : ufm_pkg::UFM_STOP;
        end
        ufm_pkg::UFM_EXTRA: if (rx_smp) begin
          rx_x_q <= s2_q;
          rx_q   <= ufm_pkg::UFM_STOP;
        end
        default: if (rx_smp) begin
          if (!rx_fin) begin // first of two stop bits
            rx_2nd_q <= 1'b1;
            rx_ok_q  <= s2_q;
            if (!has_x) rx_x_q <= s2_q;
          end else begin
            rx_q <= ufm_pkg::UFM_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- receive queue ----------------
  ufm_pkg::ufm_entry_t mem_q [DEPTH];
  ufm_pkg::ufm_entry_t q_in, head;
  logic [IW-1:0] wp_q, rp_q;
  logic [NW-1:0] cnt_q;

  wire q_in_valid  = rx_fin && stop_ok;
  wire q_in_ready  = cnt_q != FULL_N;
  wire q_out_valid = cnt_q != '0;
  wire q_out_ready = rd_dbuf;
  wire push = q_in_valid && q_in_ready;
  wire pop  = q_out_valid && q_out_ready;
  assign q_in.data = rx_data;
  assign q_in.xbit = rx_xb;
  assign q_in.perr = pe && (rx_x_q != par_f(rx_data, dl, pt));
  assign head = mem_q[rp_q];

  // circular queue with wrapping pointers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == IW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (pop)  rp_q <= (rp_q == IW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + NW'(push) - NW'(pop);
    end
  end

  // queue storage needs no reset
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wp_q] <= q_in;
  end

  // ---------------- flags and registers ----------------
  wire ovr_set  = q_in_valid && !q_in_ready;
  wire ri_set   = push && !(mce && !q_in.xbit);
  wire perr_set = push && q_in.perr;
  wire ri_clr   = wr_ctrl && !sfr_wdata_i[`UFM_B_RI] && (cnt_q < NW'(2));
  wire [7:0] ctrl_view = {ovr_q, perr_q, !hold_full_q, ren_q, tbx_q,
                          head.xbit, ti_q, ri_q};
  wire [7:0] rd_val = (sfr_addr_i == `UFM_ADDR_CTRL) ? ctrl_view :
                      (sfr_addr_i == `UFM_ADDR_DBUF) ? head.data :
                      (sfr_addr_i == `UFM_ADDR_FMT)  ? fmt_q : 8'h00;

  // sticky flags: a hardware set beats a software clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fmt_q  <= `UFM_FMT_RST;
      ren_q  <= 1'b0;
      tbx_q  <= 1'b0;
      ti_q   <= 1'b0;
      ri_q   <= 1'b0;
      ovr_q  <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      if (wr_fmt) fmt_q <= sfr_wdata_i;
      if (wr_ctrl) begin
        ren_q <= sfr_wdata_i[`UFM_B_REN];
        tbx_q <= sfr_wdata_i[`UFM_B_TBX];
      end
      ti_q   <= tx_to_stop | (wr_ctrl ? sfr_wdata_i[`UFM_B_TI] : ti_q);
      ovr_q  <= ovr_set | (wr_ctrl ? sfr_wdata_i[`UFM_B_OVR] : ovr_q);
      perr_q <= perr_set | (wr_ctrl ? sfr_wdata_i[`UFM_B_PERR] : perr_q);
      ri_q   <= ri_set | (ri_q && !ri_clr);
    end
  end

  // registered outputs; read data shows one clock after the strobe
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
      out_q   <= 1'b1;
      irq_q   <= 1'b0;
    end else begin
      if (sfr_rd_i) rdata_q <= rd_val;
      out_q <= out_d;
      irq_q <= ti_q | ri_q;
    end
  end

  assign sfr_rdata_o      = rdata_q;
  assign serial_out_pin_o = out_q;
  assign irq_o            = irq_q;

  // ---------------- checks ----------------
  chk_write_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_dbuf |=> hold_full_q) else $error("write did not fill holder");
  chk_idle_load: assert property (
    @(posedge clk_i) disable iff (reset_i)
    tx_load && !wr_dbuf |=> !hold_full_q && tx_q == ufm_pkg::UFM_START)
    else $error("idle shifter did not take byte");
  chk_busy_wait: assert property (
    @(posedge clk_i) disable iff (reset_i)
    hold_full_q && tx_q != ufm_pkg::UFM_IDLE |=> hold_full_q)
    else $error("held byte left during frame");
  chk_done_at_stop: assert property (
    @(posedge clk_i) disable iff (reset_i)
    tx_q == ufm_pkg::UFM_STOP && $past(tx_q) != ufm_pkg::UFM_STOP
    |-> ti_q) else $error("done flag missing at stop");
  chk_done_sticky: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ti_q && !wr_ctrl |=> ti_q) else $error("done flag self-cleared");
  chk_start_low: assert property (
    @(posedge clk_i) disable iff (reset_i)
    tx_q == ufm_pkg::UFM_START |=> !serial_out_pin_o)
    else $error("start bit not low");
  chk_rx_disable: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !ren_q |=> rx_q == ufm_pkg::UFM_IDLE) else $error("rx ran disabled");
  // a read in the same clock frees a slot, so the count may drop by one
  chk_overrun_flag: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ovr_set && !pop |=> ovr_q && cnt_q == FULL_N)
    else $error("overrun lost");
  chk_ri_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ri_q && cnt_q > NW'(1) |=> ri_q) else $error("rx flag cleared early");
  chk_queue_bound: assert property (
    @(posedge clk_i) disable iff (reset_i)
    cnt_q <= FULL_N) else $error("queue count too large");
endmodule

// ---- ufm_peer.sv ----
// far-end serial node model: sends frames and captures frames
`timescale 1ns/1ps
module ufm_peer #(
  parameter int BIT = 4
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  // idle line sits high, as a pulled-up receive input would
  initial line_o = 1'b1;

  // start low, lsb first, optional extra, stop, then one idle bit
  task automatic send(input logic [7:0] d, input int n, input logic xe,
                      input logic xv, input logic sv);
    logic [11:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++)
      f[1 + i] = d[i];
    f[1 + n] = xe ? xv : sv;
    f[1 + n + int'(xe)] = sv;
    for (int i = 0; i < 3 + n + int'(xe); i++) begin
      @(negedge clk_i);
      line_o = f[i];
      repeat (BIT - 1) @(negedge clk_i);
    end
  endtask

  // samples on falling edges so a registered line has settled;
  // no start within the limit leaves all zeros, which never matches
  task automatic recv(input int n, output logic [11:0] b);
    int t;
    b = '0;
    for (t = 0; t < 2000 && line_i !== 1'b0; t++)
      @(negedge clk_i);
    if (t < 2000) begin
      for (int i = 0; i < n; i++) begin
        repeat (i == 0 ? BIT / 2 : BIT) @(negedge clk_i);
        b[i] = line_i;
      end
    end
  endtask
endmodule

// ---- uart_fifo_multiproc_core_test.sv ----
// self-checking bench for the serial port core
`timescale 1ns/1ps
`include "ufm_cfg.svh"
module uart_fifo_multiproc_core_test;
  localparam int OVS = 4;
  logic        clk_i       = 1'b0;
  logic        reset_i     = 1'b1;
  logic [7:0]  sfr_addr_i  = 8'h00;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic        sfr_wr_i    = 1'b0;
  logic        sfr_rd_i    = 1'b0;
  logic        os_tick_i   = 1'b1; // a tick every clock keeps bits short
  logic        rx_line;
  logic [7:0]  sfr_rdata_o;
  logic        serial_out_pin_o;
  logic        irq_o;
  int          errors      = 0;
  int          comparisons = 0;
  logic [31:0] seed        = 32'h0e27_7c93;

  always #10 clk_i = ~clk_i;

  ufm_core #(.OVS(OVS), .DEPTH(3)) uut (
    .clk_i            (clk_i),
    .reset_i          (reset_i),
    .sfr_addr_i       (sfr_addr_i),
    .sfr_wdata_i      (sfr_wdata_i),
    .sfr_wr_i         (sfr_wr_i),
    .sfr_rd_i         (sfr_rd_i),
    .os_tick_i        (os_tick_i),
    .serial_in_pin_i  (rx_line),
    .sfr_rdata_o      (sfr_rdata_o),
    .serial_out_pin_o (serial_out_pin_o),
    .irq_o            (irq_o)
  );

  ufm_peer #(.BIT(OVS)) peer (
    .clk_i  (clk_i),
    .line_i (serial_out_pin_o),
    .line_o (rx_line)
  );

  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // expected wire bits from start to first stop, start in bit 0
  function automatic logic [11:0] frame(input logic [7:0] d, input int n,
      input logic pe, input logic [1:0] pt, input logic xv);
    logic        p;
    logic [11:0] f;
    p = pt[1] ? ~pt[0] : (^(d & (8'hff >> (8 - n)))) ^ ~pt[0];
    f = '0;
    for (int i = 0; i < n; i++)
      f[1 + i] = d[i];
    f[1 + n] = pe ? p : xv; // parity wins over the extra bit
    f[2 + n] = 1'b1;
    return f;
  endfunction

  task summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(nm, {4'h0, e}, {4'h0, v});
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    summarize();
  end

  initial begin
    logic [7:0]  a, b, c, v;
    logic [7:0]  q[4];
    logic [11:0] g1, g2, e;
    int          n;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    rchk("ctrl", `UFM_ADDR_CTRL, `UFM_CTRL_RST);
    rchk("fmt", `UFM_ADDR_FMT, `UFM_FMT_RST);
    rchk("dbuf", `UFM_ADDR_DBUF, `UFM_DBUF_RST);
    rchk("unmapped", 8'h00, 8'h00);
    $display("reset test done");
    // every length, even or space parity or the extra bit, second byte queued behind the first
    for (int dl = 0; dl < 4; dl++) begin
      n = 5 + dl;
      a = rnd();
      b = rnd();
      v = rnd();
      wr(`UFM_ADDR_FMT, {1'b0, dl[1:0], dl[0], dl[1:0], 1'b1, dl[1]});
      wr(`UFM_ADDR_CTRL, {4'h0, v[0], 3'h0});
      fork
        begin
          peer.recv(3 + n, g1);
          peer.recv(3 + n, g2);
        end
        begin
          wr(`UFM_ADDR_DBUF, a);
          repeat (2) @(negedge clk_i); // holder empty again
          wr(`UFM_ADDR_DBUF, b);
          rd(`UFM_ADDR_CTRL, c);
          chk("hold busy", 12'h000, {11'h0, c[5]});
        end
      join
      e = frame(a, n, dl[0], dl[1:0], v[0]);
      chk("frame a", e, g1);
      e = frame(b, n, dl[0], dl[1:0], v[0]);
      chk("frame b", e, g2);
      rd(`UFM_ADDR_CTRL, c);
      chk("ctrl tx", {4'h2, v[0], 3'b010}, c & 8'hfb);
      chk("irq", 12'h001, {11'h0, irq_o});
    end
    $display("transmit test done");
    // receive: bad stop dropped, then one byte more than the queue holds
    wr(`UFM_ADDR_FMT, 8'h0c); // point to point link
    wr(`UFM_ADDR_CTRL, 8'h10);
    peer.send(rnd(), 8, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      q[i] = rnd();
      peer.send(q[i], 8, 1'b0, 1'b0, 1'b1);
    end
    rchk("ctrl full", `UFM_ADDR_CTRL, 8'hb5);
    wr(`UFM_ADDR_CTRL, 8'h10);
    rchk("rx flag held", `UFM_ADDR_CTRL, 8'h35);
    for (int i = 0; i < 3; i++)
      rchk("rx byte", `UFM_ADDR_DBUF, q[i]);
    wr(`UFM_ADDR_CTRL, 8'h10);
    rd(`UFM_ADDR_CTRL, c);
    chk("rx flag clear", 12'h030, c & 8'hfb);
    $display("receive test done");
    // parity: a good byte then a bad one under even parity
    wr(`UFM_ADDR_FMT, 8'h3c);
    a = rnd();
    peer.send(a, 8, 1'b1, ^a, 1'b1);
    rd(`UFM_ADDR_CTRL, c);
    chk("parity ok", 12'h000, {11'h0, c[6]});
    peer.send(a, 8, 1'b1, ~^a, 1'b1);
    rd(`UFM_ADDR_CTRL, c);
    chk("parity bad", 12'h001, {11'h0, c[6]});
    rd(`UFM_ADDR_DBUF, v);
    rd(`UFM_ADDR_DBUF, v);
    wr(`UFM_ADDR_CTRL, 8'h10);
    // address mode: data byte stays silent, address byte raises the flag
    wr(`UFM_ADDR_FMT, 8'h8e); // multidrop node
    a = rnd();
    b = rnd();
    peer.send(a, 8, 1'b1, 1'b0, 1'b1); // data byte
    rd(`UFM_ADDR_CTRL, c);
    chk("data gated", 12'h000, {10'h0, c[2], c[0]});
    peer.send(b, 8, 1'b1, 1'b1, 1'b1); // address byte
    rd(`UFM_ADDR_CTRL, c);
    chk("addr seen", 12'h001, {10'h0, c[2], c[0]});
    // receiver off: this frame must not land in the queue
    wr(`UFM_ADDR_CTRL, 8'h00);
    v = rnd();
    peer.send(~v, 8, 1'b1, 1'b1, 1'b1);
    wr(`UFM_ADDR_CTRL, 8'h10);
    peer.send(v, 8, 1'b1, 1'b1, 1'b1);
    rchk("queued a", `UFM_ADDR_DBUF, a);
    rchk("queued b", `UFM_ADDR_DBUF, b);
    rchk("queued next", `UFM_ADDR_DBUF, v);
    $display("address and enable test done");
    summarize();
  end
endmodule
